// File: hdl/itp_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module itp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset.
    input  wire logic             clk_in,
    input  wire logic             resetn_in,
    // Fill side.
    input  wire logic [WIDTH-1:0] wr_data_in,
    input  wire logic             wr_valid_in,
    output logic                  wr_ready_out,
    // Drain side.
    output logic [WIDTH-1:0]      rd_data_out,
    output logic                  rd_valid_out,
    input  wire logic             rd_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0]      wr_ptr_reg;
    logic [AW:0]      rd_ptr_reg;
    logic             full;
    logic             empty;
    assign full  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
    assign empty = (wr_ptr_reg == rd_ptr_reg);
    assign wr_ready_out = !full;
    assign rd_valid_out = !empty;
    assign rd_data_out  = mem_reg[rd_ptr_reg[AW-1:0]];
    always_ff @(posedge clk_in) begin
        if (wr_valid_in && !full) begin
            mem_reg[wr_ptr_reg[AW-1:0]] <= wr_data_in;
        end
    end
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wr_ptr_reg <= '0;
        end else if (wr_valid_in && !full) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
        end
    end
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rd_ptr_reg <= '0;
        end else if (rd_ready_in && !empty) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
    end
endmodule
`default_nettype wire

// File: hdl/itp_pkg.sv
// Package of constants and types for the two-wire sensor target port.
package itp_pkg;
    localparam logic [6:0]  TARGET_ADDR_LOW   = 7'h68;
    localparam logic [6:0]  TARGET_ADDR_HIGH  = 7'h69;
    localparam logic [7:0]  REG_ADDR_RESET    = 8'h00;
    localparam int          SYS_CLK_HZ        = 10000000;
    localparam int          WDT_SHORT_US      = 1000;
    localparam int          WDT_LONG_US       = 50000;
    localparam int          WDT_SHORT_CYC     = (SYS_CLK_HZ / 1000000) * WDT_SHORT_US;
    localparam int          WDT_LONG_CYC      = (SYS_CLK_HZ / 1000000) * WDT_LONG_US;
    localparam int          WRITE_GAP_NORMAL_NS = 1300;
    localparam int          BYTE_WIDTH        = 8;
    localparam int          FIFO_DEPTH        = 32;
    localparam logic [3:0]  BIT_COUNT_RESET   = 4'h0;
    localparam logic [3:0]  BIT_COUNT_ACK     = 4'h8;
    localparam logic [22:0] WDT_COUNT_RESET   = 23'h000000;

    typedef enum logic [2:0] {
        ITP_IDLE,
        ITP_ADDR,
        ITP_ADDR_ACK,
        ITP_REG,
        ITP_REG_ACK,
        ITP_WDATA,
        ITP_WDATA_ACK,
        ITP_RDATA
    } itp_state_e;
endpackage

// File: hdl/itp_target_port.sv
// Two-wire target port of the sensor, oversampling the bus on the link clock.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Answer to address 0x68 with the strap low and 0x69 with the strap high.
// - Only 7-bit addressing is recognised; no 10-bit addressing.
// - Clock rates up to 1 MHz are accepted with fast-mode timing.
// - A falling data edge while the clock is high is a start and marks the bus busy.
// - A rising data edge while the clock is high is a stop and returns the port to idle.
// - The receiver pulls data low through the ninth clock to acknowledge; the sender lets go.
// - A stop directly after a start with no clock toggle is not recognised.
// - A write is address with RW 0, register byte, data byte, each acknowledged, then stop.
// - A read is a write phase with the register byte, repeated start, address with RW 1.
// - The controller acknowledges to get more bytes; a not-acknowledge ends sending.
// - The register address increments after each byte read that the controller acknowledges.
// - A read starts at the latest written register address, which is 0x00 after reset.
// - A watchdog resets the port when the device holds the bus locked.
// - The watchdog enable bit turns the watchdog on when one and off when zero.
// - The period select bit gives 1 ms when zero and 50 ms when one.
module itp_target_port
    import itp_pkg::*;
#(
    parameter int WDT_SHORT = WDT_SHORT_CYC,
    parameter int WDT_LONG  = WDT_LONG_CYC
) (
    // Clocks and reset.
    input  wire logic        clk_sys_in,
    input  wire logic        resetn_in,
    input  wire logic        clk_link_in,
    // Bus pins.
    input  wire logic        primary_serial_clock_pin_in,
    input  wire logic        primary_serial_data_pin_in,
    output logic             primary_serial_data_pin_out,
    output logic             primary_serial_data_pin_oe_out,
    // Configuration.
    input  wire logic        addr_strap_in,
    input  wire logic        wdt_enable_in,
    input  wire logic        wdt_long_period_in,
    // Register map write side.
    output logic [7:0]       reg_wr_addr_out,
    output logic [7:0]       reg_wr_data_out,
    output logic             reg_wr_valid_out,
    input  wire logic        reg_wr_ready_in,
    // Register map read side.
    output logic [7:0]       reg_rd_addr_out,
    input  wire logic [7:0]  reg_rd_data_in,
    // Status.
    output logic             bus_busy_out,
    output logic             wdt_timeout_out
);
    // Link clock oversamples the pins; the system domain holds the watchdog.
    logic [1:0] scl_sync_reg;
    logic [1:0] sda_sync_reg;
    logic       scl_d_reg;
    logic       sda_d_reg;
    logic       scl;
    logic       sda;
    logic       start_det;
    logic       stop_det;
    logic       scl_rise;
    logic       scl_fall;

    always_ff @(posedge clk_link_in or negedge resetn_in) begin
        if (!resetn_in) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            scl_d_reg    <= 1'b1;
            sda_d_reg    <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], primary_serial_clock_pin_in};
            sda_sync_reg <= {sda_sync_reg[0], primary_serial_data_pin_in};
            scl_d_reg    <= scl_sync_reg[1];
            sda_d_reg    <= sda_sync_reg[1];
        end
    end
    assign scl = scl_sync_reg[1];
    assign sda = sda_sync_reg[1];
    assign start_det = scl && scl_d_reg && sda_d_reg && !sda;
    assign stop_det  = scl && scl_d_reg && !sda_d_reg && sda;
    assign scl_rise  = scl && !scl_d_reg;
    assign scl_fall  = !scl && scl_d_reg;

    // Watchdog timeout request crosses from the system domain by a toggle.
    logic [2:0] wdt_tog_sync_reg;
    logic       wdt_tog_reg;
    logic       wdt_kill;
    assign wdt_kill = wdt_tog_sync_reg[2] ^ wdt_tog_sync_reg[1];

    itp_state_e state_reg;
    logic [7:0] shift_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] reg_addr_reg;
    logic [7:0] rd_addr_reg;
    logic [7:0] rd_start_reg;
    logic       first_reg_reg;
    logic       clock_seen_reg;
    logic       busy_reg;
    logic       sda_drive_reg;
    logic       our_addr;
    logic [6:0] my_addr;
    logic       push_valid;
    logic       push_ready;
    logic [7:0] push_data;

    assign my_addr  = addr_strap_in ? TARGET_ADDR_HIGH : TARGET_ADDR_LOW;
    assign our_addr = (shift_reg[7:1] == my_addr);

    // Clock seen since start: a stop straight after a start is ignored.
    always_ff @(posedge clk_link_in or negedge resetn_in) begin
        if (!resetn_in) begin
            clock_seen_reg <= 1'b0;
        end else if (start_det) begin
            clock_seen_reg <= 1'b0;
        end else if (scl_fall) begin
            clock_seen_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_link_in or negedge resetn_in) begin
        if (!resetn_in) begin
            busy_reg <= 1'b0;
        end else if (start_det) begin
            busy_reg <= 1'b1;
        end else if ((stop_det && clock_seen_reg) || wdt_kill) begin
            busy_reg <= 1'b0;
        end
    end

    // Serial state machine; bits sampled on clock rise, data driven on clock fall.
    always_ff @(posedge clk_link_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_reg     <= ITP_IDLE;
            shift_reg     <= 8'h00;
            bit_cnt_reg   <= BIT_COUNT_RESET;
            reg_addr_reg  <= REG_ADDR_RESET;
            rd_addr_reg   <= REG_ADDR_RESET;
            rd_start_reg  <= REG_ADDR_RESET;
            first_reg_reg <= 1'b0;
            sda_drive_reg <= 1'b0;
        end else if (wdt_kill) begin
            state_reg     <= ITP_IDLE;
            sda_drive_reg <= 1'b0;
            bit_cnt_reg   <= BIT_COUNT_RESET;
        end else if (start_det) begin
            state_reg     <= ITP_ADDR;
            bit_cnt_reg   <= BIT_COUNT_RESET;
            sda_drive_reg <= 1'b0;
            // Every transfer reads from the retained start, not from where the last read ended.
            rd_addr_reg   <= rd_start_reg;
        end else if (stop_det && clock_seen_reg) begin
            state_reg     <= ITP_IDLE;
            sda_drive_reg <= 1'b0;
        end else begin
            case (state_reg)
                ITP_IDLE: begin
                    sda_drive_reg <= 1'b0;
                end
                ITP_ADDR, ITP_REG, ITP_WDATA: begin
                    if (scl_rise) begin
                        shift_reg   <= {shift_reg[6:0], sda};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (scl_fall && bit_cnt_reg == BIT_COUNT_ACK) begin
                        bit_cnt_reg <= BIT_COUNT_RESET;
                        if (state_reg == ITP_ADDR && !our_addr) begin
                            state_reg <= ITP_IDLE;
                        end else if (state_reg == ITP_WDATA && !push_ready) begin
                            state_reg <= ITP_IDLE;
                        end else begin
                            sda_drive_reg <= 1'b1;
                            if (state_reg == ITP_ADDR) begin
                                state_reg <= ITP_ADDR_ACK;
                            end else if (state_reg == ITP_REG) begin
                                reg_addr_reg <= shift_reg;
                                rd_addr_reg  <= shift_reg;
                                rd_start_reg <= shift_reg;
                                state_reg    <= ITP_REG_ACK;
                            end else begin
                                state_reg    <= ITP_WDATA_ACK;
                            end
                        end
                    end
                end
                ITP_ADDR_ACK, ITP_REG_ACK, ITP_WDATA_ACK: begin
                    if (scl_fall) begin
                        sda_drive_reg <= 1'b0;
                        if (state_reg == ITP_ADDR_ACK && shift_reg[0]) begin
                            state_reg     <= ITP_RDATA;
                            shift_reg     <= reg_rd_data_in;
                            sda_drive_reg <= !reg_rd_data_in[7];
                            bit_cnt_reg   <= BIT_COUNT_RESET;
                        end else if (state_reg == ITP_ADDR_ACK) begin
                            state_reg <= ITP_REG;
                        end else if (state_reg == ITP_REG_ACK) begin
                            state_reg <= ITP_WDATA;
                        end else begin
                            reg_addr_reg <= reg_addr_reg + 8'h01;
                            state_reg    <= ITP_WDATA;
                        end
                    end
                end
                ITP_RDATA: begin
                    if (scl_rise && bit_cnt_reg == BIT_COUNT_ACK) begin
                        if (sda) begin
                            state_reg <= ITP_IDLE;
                        end else begin
                            rd_addr_reg <= rd_addr_reg + 8'h01;
                            bit_cnt_reg <= BIT_COUNT_ACK + 4'h1;
                        end
                    end else if (scl_rise) begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (scl_fall && bit_cnt_reg == BIT_COUNT_ACK) begin
                        sda_drive_reg <= 1'b0;
                    end else if (scl_fall && bit_cnt_reg == BIT_COUNT_ACK + 4'h1) begin
                        bit_cnt_reg   <= BIT_COUNT_RESET;
                        shift_reg     <= reg_rd_data_in;
                        sda_drive_reg <= !reg_rd_data_in[7];
                    end else if (scl_fall) begin
                        sda_drive_reg <= !shift_reg[6];
                        shift_reg     <= {shift_reg[6:0], 1'b0};
                    end
                end
                default: begin
                    state_reg <= ITP_IDLE;
                end
            endcase
        end
    end

    // Written bytes go through the FIFO so a slow register map stalls with a not-acknowledge.
    logic       fifo_out_valid;
    logic [15:0] fifo_out_data;
    assign push_valid = (state_reg == ITP_WDATA) && scl_fall && (bit_cnt_reg == BIT_COUNT_ACK);
    assign push_data  = shift_reg;

    itp_fifo #(
        .WIDTH(2 * BYTE_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_in      (clk_link_in),
        .resetn_in   (resetn_in),
        .wr_data_in  ({reg_addr_reg, push_data}),
        .wr_valid_in (push_valid),
        .wr_ready_out(push_ready),
        .rd_data_out (fifo_out_data),
        .rd_valid_out(fifo_out_valid),
        .rd_ready_in (reg_wr_ready_in)
    );
    assign reg_wr_addr_out  = fifo_out_data[15:8];
    assign reg_wr_data_out  = fifo_out_data[7:0];
    assign reg_wr_valid_out = fifo_out_valid;
    assign reg_rd_addr_out  = rd_addr_reg;

    assign primary_serial_data_pin_out    = 1'b0;
    assign primary_serial_data_pin_oe_out = sda_drive_reg;

    // Watchdog in the system domain: counts while the device holds data low.
    logic [1:0]  drv_sync_reg;
    logic [1:0]  busy_sync_reg;
    logic [22:0] wdt_cnt_reg;
    logic [22:0] wdt_limit;
    logic        wdt_pulse_reg;
    assign wdt_limit = wdt_long_period_in ? 23'(WDT_LONG) : 23'(WDT_SHORT);

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            drv_sync_reg  <= 2'h0;
            busy_sync_reg <= 2'h0;
        end else begin
            drv_sync_reg  <= {drv_sync_reg[0], sda_drive_reg};
            busy_sync_reg <= {busy_sync_reg[0], busy_reg};
        end
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wdt_cnt_reg   <= WDT_COUNT_RESET;
            wdt_tog_reg   <= 1'b0;
            wdt_pulse_reg <= 1'b0;
        end else begin
            wdt_pulse_reg <= 1'b0;
            if (!wdt_enable_in || !drv_sync_reg[1]) begin
                wdt_cnt_reg <= WDT_COUNT_RESET;
            end else if (wdt_cnt_reg >= wdt_limit - 23'h1) begin
                wdt_cnt_reg   <= WDT_COUNT_RESET;
                wdt_tog_reg   <= !wdt_tog_reg;
                wdt_pulse_reg <= 1'b1;
            end else begin
                wdt_cnt_reg <= wdt_cnt_reg + 23'h1;
            end
        end
    end

    always_ff @(posedge clk_link_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wdt_tog_sync_reg <= 3'h0;
        end else begin
            wdt_tog_sync_reg <= {wdt_tog_sync_reg[1:0], wdt_tog_reg};
        end
    end

    assign bus_busy_out    = busy_sync_reg[1];
    assign wdt_timeout_out = wdt_pulse_reg;

    // Checks in the link domain; only the watchdog counter check, a_wdt_off, and the cover c_wdt_fire run in the system domain.
    a_start_busy: assert property (@(posedge clk_link_in) disable iff (!resetn_in)
        start_det && !wdt_kill |=> busy_reg && state_reg == ITP_ADDR)
        else $error("start did not mark bus busy");
    a_stop_idle: assert property (@(posedge clk_link_in) disable iff (!resetn_in)
        stop_det && clock_seen_reg && !start_det |=> state_reg == ITP_IDLE && !sda_drive_reg)
        else $error("stop did not return to idle");
    a_bare_stop: assert property (@(posedge clk_link_in) disable iff (!resetn_in)
        stop_det && !clock_seen_reg && busy_reg && !wdt_kill |=> busy_reg)
        else $error("stop right after start was recognised");
    a_wrong_addr: assert property (@(posedge clk_link_in) disable iff (!resetn_in)
        state_reg == ITP_ADDR && scl_fall && bit_cnt_reg == BIT_COUNT_ACK && !our_addr
        && !start_det && !stop_det && !wdt_kill |=> !sda_drive_reg)
        else $error("acknowledged a foreign address");
    a_ack_drive: assert property (@(posedge clk_link_in) disable iff (!resetn_in)
        state_reg == ITP_REG && scl_fall && bit_cnt_reg == BIT_COUNT_ACK
        && !start_det && !stop_det && !wdt_kill |=> sda_drive_reg && state_reg == ITP_REG_ACK)
        else $error("register byte not acknowledged");
    a_nack_ends: assert property (@(posedge clk_link_in) disable iff (!resetn_in)
        state_reg == ITP_RDATA && scl_rise && bit_cnt_reg == BIT_COUNT_ACK && sda
        && !start_det && !stop_det && !wdt_kill |=> state_reg == ITP_IDLE ##1 !sda_drive_reg)
        else $error("read continued after not-acknowledge");
    a_read_incr: assert property (@(posedge clk_link_in) disable iff (!resetn_in)
        state_reg == ITP_RDATA && scl_rise && bit_cnt_reg == BIT_COUNT_ACK && !sda
        && !start_det && !stop_det && !wdt_kill |=> rd_addr_reg == $past(rd_addr_reg) + 8'h01)
        else $error("read address not incremented");
    a_wdt_release: assert property (@(posedge clk_link_in) disable iff (!resetn_in)
        wdt_kill |=> state_reg == ITP_IDLE && !sda_drive_reg)
        else $error("watchdog did not release the bus");
    a_wdt_off: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        !wdt_enable_in |=> wdt_cnt_reg == WDT_COUNT_RESET && !wdt_pulse_reg)
        else $error("watchdog counted while disabled");

    c_write: cover property (@(posedge clk_link_in) disable iff (!resetn_in)
        push_valid && push_ready);
    c_read_more: cover property (@(posedge clk_link_in) disable iff (!resetn_in)
        state_reg == ITP_RDATA && scl_rise && bit_cnt_reg == BIT_COUNT_ACK && !sda);
    c_wdt_fire: cover property (@(posedge clk_sys_in) disable iff (!resetn_in)
        wdt_pulse_reg);
endmodule
`default_nettype wire

// File: test/itp_ctrl_model.sv
// Behavioural two-wire bus controller that drives the bus clock and pulls data low.
`timescale 1ns/1ps
`default_nettype none
module itp_ctrl_model (
    // Timing reference.
    input  wire logic clk_in,
    // Bus lines; data is released to the pull-up when pull_out is low.
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      pull_out
);
    initial begin
        scl_out = 1'b1;
        pull_out = 1'b0;
    end
    // Data changes only while the clock is low, so no bit looks like a start or stop.
    task automatic bit_cyc(input logic pull, output logic seen);
        @(posedge clk_in) scl_out <= 1'b0;
        @(posedge clk_in) pull_out <= pull;
        @(posedge clk_in) scl_out <= 1'b1;
        repeat (2) @(posedge clk_in);
        seen = sda_in;
    endtask
    task automatic start();
        @(posedge clk_in) scl_out <= 1'b0;
        @(posedge clk_in) pull_out <= 1'b0;
        @(posedge clk_in) scl_out <= 1'b1;
        @(posedge clk_in);
        @(posedge clk_in) pull_out <= 1'b1;
        @(posedge clk_in);
    endtask
    task automatic stop();
        @(posedge clk_in) scl_out <= 1'b0;
        @(posedge clk_in) pull_out <= 1'b1;
        @(posedge clk_in) scl_out <= 1'b1;
        @(posedge clk_in);
        @(posedge clk_in) pull_out <= 1'b0;
        repeat (14) @(posedge clk_in);
    endtask
    // Releases data right after a start with no clock pulse in between.
    task automatic bare_stop();
        @(posedge clk_in) pull_out <= 1'b0;
        repeat (14) @(posedge clk_in);
    endtask
    // With stall set the clock is parked low where the target acknowledges.
    task automatic send_byte(input logic [7:0] b, input logic stall, output logic ack);
        logic s;
        ack = 1'b0;
        for (int i = 7; i >= 0; i--) bit_cyc(~b[i], s);
        if (stall) begin
            @(posedge clk_in) scl_out <= 1'b0;
            @(posedge clk_in) pull_out <= 1'b0;
        end else begin
            bit_cyc(1'b0, s);
            ack = ~s;
        end
    endtask
    task automatic recv_byte(input logic give_ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(1'b0, s);
            b[i] = s;
        end
        bit_cyc(give_ack, s);
    endtask
endmodule
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench for the target port against a behavioural register map.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import itp_pkg::*;
    localparam int WS = 200;
    localparam int WL = 400;
    logic       clk_sys_in, clk_link_in, resetn_in, strap, wdt_en, wdt_long;
    logic       wr_ready, ready_en, scl, pull, dout, oe, sda, wr_valid, busy, wdt_to;
    logic [7:0] wr_addr, wr_data, rd_addr, rd_data;
    logic [7:0] mem [256];
    logic [15:0] exp_q [$];
    int         n_mismatch = 0;
    int         total_checks = 0;
    int         cyc = 0;
    assign sda = !(pull || (oe && !dout));
    assign rd_data = mem[rd_addr];
    itp_ctrl_model ctrl (.clk_in(clk_sys_in), .sda_in(sda), .scl_out(scl), .pull_out(pull));
    itp_target_port #(.WDT_SHORT(WS), .WDT_LONG(WL)) uut (
        .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .clk_link_in(clk_link_in),
        .primary_serial_clock_pin_in(scl), .primary_serial_data_pin_in(sda),
        .primary_serial_data_pin_out(dout), .primary_serial_data_pin_oe_out(oe),
        .addr_strap_in(strap), .wdt_enable_in(wdt_en), .wdt_long_period_in(wdt_long),
        .reg_wr_addr_out(wr_addr), .reg_wr_data_out(wr_data), .reg_wr_valid_out(wr_valid),
        .reg_wr_ready_in(wr_ready), .reg_rd_addr_out(rd_addr), .reg_rd_data_in(rd_data),
        .bus_busy_out(busy), .wdt_timeout_out(wdt_to));
    initial begin
        clk_sys_in = 1'b0;
        forever #50 clk_sys_in = ~clk_sys_in;
    end
    // The link clock starts off phase so its edges never line up with the system clock.
    initial begin
        clk_link_in = 1'b0;
        #7;
        forever #15 clk_link_in = ~clk_link_in;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] expd);
        total_checks++;
        if (seen !== expd) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, expd);
        end
    endtask
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 40000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    // Drain side of the write queue, stalling at random.
    always @(posedge clk_link_in) begin
        if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
            check(16'(exp_q.size() != 0), 16'h0001);
            if (exp_q.size() != 0) check({wr_addr, wr_data}, exp_q.pop_front());
        end
        wr_ready <= ready_en && ($urandom_range(1) == 1);
    end
    task automatic put(input logic [7:0] b, input logic exp_ack);
        logic a;
        ctrl.send_byte(b, 1'b0, a);
        check(16'(a), 16'(exp_ack));
    endtask
    task automatic get(input int n, input logic [7:0] a0);
        logic [7:0] b, a;
        a = a0;
        for (int i = 0; i < n; i++) begin
            ctrl.recv_byte(i < n - 1, b);
            check(16'(b), 16'(mem[a]));
            a = a + 8'h01;
        end
    endtask
    task automatic drain();
        int k;
        k = 0;
        while (exp_q.size() != 0 && k < 3000) begin
            @(posedge clk_sys_in);
            k++;
        end
        repeat (4) @(posedge clk_sys_in);
        check(16'(exp_q.size()), 16'h0000);
        check(16'(wr_valid), 16'h0000);
    endtask
    initial begin
        logic [7:0] r, d;
        logic       a;
        int         k, n, lim;
        void'($urandom(32'h4C2721B4));
        {resetn_in, strap, wdt_en, wdt_long, ready_en} = 5'h00;
        for (k = 0; k < 256; k++) mem[k] = 8'($urandom);
        repeat (16) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        repeat (4) @(posedge clk_sys_in);
        ctrl.start();
        put({TARGET_ADDR_LOW, 1'b1}, 1'b1);
        check(16'(busy), 16'h0001);
        get(2, REG_ADDR_RESET);
        ctrl.stop();
        check(16'(busy), 16'h0000);
        ctrl.start();
        put({TARGET_ADDR_HIGH, 1'b0}, 1'b0);
        ctrl.stop();
        ctrl.start();
        put(8'hF0, 1'b0);
        ctrl.stop();
        // Fill the queue with the drain stalled; the word after it is full is refused.
        r = 8'($urandom);
        ctrl.start();
        put({TARGET_ADDR_LOW, 1'b0}, 1'b1);
        put(r, 1'b1);
        for (k = 0; k <= FIFO_DEPTH; k++) begin
            d = 8'($urandom);
            if (k < FIFO_DEPTH) exp_q.push_back({r + 8'(k), d});
            put(d, k < FIFO_DEPTH);
        end
        ctrl.stop();
        ready_en <= 1'b1;
        drain();
        r = 8'($urandom);
        ctrl.start();
        put({TARGET_ADDR_LOW, 1'b0}, 1'b1);
        put(r, 1'b1);
        ctrl.start();
        put({TARGET_ADDR_LOW, 1'b1}, 1'b1);
        get(4, r);
        ctrl.stop();
        check(16'(busy), 16'h0000);
        ctrl.start();
        put({TARGET_ADDR_LOW, 1'b1}, 1'b1);
        get(3, r);
        ctrl.stop();
        ctrl.start();
        ctrl.bare_stop();
        check(16'(busy), 16'h0001);
        ctrl.start();
        put({TARGET_ADDR_LOW, 1'b0}, 1'b1);
        put(r, 1'b1);
        exp_q.push_back({r, mem[0]});
        put(mem[0], 1'b1);
        ctrl.stop();
        check(16'(busy), 16'h0000);
        drain();
        // Park the clock where the target acknowledges, so the target holds data low.
        for (k = 0; k < 3; k++) begin
            wdt_en <= (k < 2);
            wdt_long <= (k == 1);
            lim = (k == 0) ? WS : (k == 1) ? WL : 600;
            ctrl.start();
            ctrl.send_byte({TARGET_ADDR_LOW, 1'b0}, 1'b1, a);
            n = 0;
            while (oe !== 1'b1 && n < 50) begin
                @(posedge clk_sys_in);
                n++;
            end
            n = 0;
            while (wdt_to !== 1'b1 && n < lim + 10) begin
                @(posedge clk_sys_in);
                n++;
            end
            check(16'(n >= lim - 2 && n < lim + 10), 16'(k < 2));
            repeat (20) @(posedge clk_sys_in);
            check(16'(oe), 16'(k == 2));
        end
        ctrl.bit_cyc(1'b0, a);
        ctrl.stop();
        resetn_in <= 1'b0;
        strap <= 1'b1;
        repeat (4) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        repeat (4) @(posedge clk_sys_in);
        ctrl.start();
        put({TARGET_ADDR_HIGH, 1'b0}, 1'b1);
        ctrl.stop();
        ctrl.start();
        put({TARGET_ADDR_LOW, 1'b0}, 1'b0);
        ctrl.stop();
        wrap_up();
    end
endmodule
`default_nettype wire
